// File: hdl/tpslc_pkg.sv
// Purpose: Shared constants and types for the touch power state and LED control block
// Assumes: 50 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: Register offsets are byte addresses
package tpslc_pkg;
  localparam int CLK_MHZ = 50;
  // Reset pin glitch filter time in ns
  localparam int T_RST_FILT_NS = 10000;
  localparam int RST_FILT_CYC = (T_RST_FILT_NS * CLK_MHZ + 999) / 1000;
  // Clock cycles per PWM step of LED channels 0 to 9; channel 10 takes twice as many
  localparam int PWM_DIV = 4;
  // Cycles the alert pin is ignored after entering deep sleep
  localparam logic [1:0] ALERT_GUARD = 2'h3;

  typedef enum logic [1:0] {PS_ACTIVE, PS_SLEEP, PS_DEEP, PS_INACT} tpslc_pstate_t;
  typedef enum logic [1:0] {LM_DIRECT, LM_PULSE1, LM_PULSE2, LM_BREATHE} tpslc_mode_t;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_SMASK = 8'h08;
  localparam logic [7:0] OFS_TOUCH = 8'h0C;
  localparam logic [7:0] OFS_DRIVE = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_PPSEL = 8'h18;
  localparam logic [7:0] OFS_LIMIT = 8'h1C;
  localparam logic [7:0] OFS_LIDSEL = 8'h20;
  localparam logic [7:0] OFS_SLIDER = 8'h24;
  localparam logic [7:0] OFS_LEDCFG = 8'h28;
  localparam logic [7:0] OFS_LEDALT = 8'h2C;

  localparam int CTRL_SLEEP = 0;
  localparam int CTRL_INACT = 1;
  localparam int CTRL_DEEP = 2;
  localparam int CTRL_PWR = 3;
  localparam int CTRL_LINK = 4;
  localparam int CTRL_SLPOS = 5;
  localparam int STAT_RST = 2;
  localparam int STAT_LID = 3;
  localparam int STAT_DONE = 4;
  localparam int STAT_LIDEV = 5;

  localparam logic [7:0] RST_BRIGHT = 8'hFF;
  localparam logic [3:0] RST_PULSES = 4'h3;
  localparam logic [3:0] RST_MAX_BTN = 4'h3;
  localparam logic [3:0] RST_MAX_GRP = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hdl/tpslc_rst_filter.sv
// Purpose: Synchronise and deglitch the active-high reset pin
// Assumes: Pin is asynchronous to aclk
// Notes: Pulse on release marks the end of a held reset
`timescale 1ns/1ps
`default_nettype none
module tpslc_rst_filter #(
  parameter int FILT_CYC = tpslc_pkg::RST_FILT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic hold,
  output logic released
);
  if (FILT_CYC < 1 || FILT_CYC > 65535) begin : g_bad
    $error("tpslc_rst_filter: FILT_CYC out of range");
  end
  typedef struct packed {
    logic s1, s2, last, lvl, rel;
    logic [15:0] cnt;
  } tpslc_filt_t;
  tpslc_filt_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin;
    s_nxt.s2 = s_r.s1;
    s_nxt.rel = 1'b0;
    if (s_r.s2 != s_r.last) begin
      s_nxt.last = s_r.s2;
      s_nxt.cnt = '0;
    end else if (s_r.last != s_r.lvl) begin
      if (s_r.cnt == 16'(FILT_CYC - 1)) begin
        s_nxt.lvl = s_r.last;
        s_nxt.rel = !s_r.last;
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign hold = s_r.lvl;
  assign released = s_r.rel;

  AST_FILT_ACCEPT: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(s_r.lvl) |-> $past(s_r.cnt) == 16'(FILT_CYC - 1))
    else $error("reset level accepted before filter time");
endmodule // tpslc_rst_filter
`default_nettype wire

// File: hdl/tpslc_led.sv
// Purpose: One LED channel with direct, pulse and breathe behaviours
// Assumes: tick is a one-cycle PWM step enable
// Notes: Minimum brightness is off; maximum is the brightness setting
`timescale 1ns/1ps
`default_nettype none
module tpslc_led (
  input wire logic aclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic stim,
  input wire logic [1:0] mode,
  input wire logic [7:0] bright,
  input wire logic [3:0] pulses,
  output logic on,
  output logic done
);
  typedef struct packed {
    logic [7:0] pwm;
    logic [3:0] cnt;
    logic phase, busy, stim_d, on, done;
  } tpslc_led_t;
  tpslc_led_t s_r, s_nxt;
  logic rise, fall, wrap, start, lit;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.stim_d = stim;
    rise = stim && !s_r.stim_d;
    fall = !stim && s_r.stim_d;
    wrap = tick && s_r.pwm == 8'hFF;
    start = 1'b0;
    lit = 1'b0;
    if (!run) begin
      s_nxt = '0;
    end else begin
      if (tick) s_nxt.pwm = s_r.pwm + 8'h01;
      if (wrap) s_nxt.phase = !s_r.phase;
      unique case (tpslc_pkg::tpslc_mode_t'(mode))
        tpslc_pkg::LM_DIRECT: begin
          lit = stim;
          s_nxt.done = fall;
        end
        tpslc_pkg::LM_PULSE1: begin
          start = rise;
          lit = s_r.busy && s_r.phase;
        end
        tpslc_pkg::LM_PULSE2: begin
          start = fall;
          lit = stim ? s_r.phase : (s_r.busy && s_r.phase);
        end
        tpslc_pkg::LM_BREATHE: begin
          lit = stim && s_r.phase;
          s_nxt.done = fall;
        end
      endcase
      if (s_r.busy && wrap && s_r.phase) begin
        if (s_r.cnt <= 4'h1) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      if (start && pulses != 4'h0) begin
        s_nxt.busy = 1'b1;
        s_nxt.cnt = pulses;
        s_nxt.phase = 1'b0;
      end
      s_nxt.on = lit && (bright == 8'hFF || s_r.pwm < bright);
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign on = s_r.on;
  assign done = s_r.done;

  AST_LED_IDLE: assert property (@(posedge aclk) disable iff (!rst_n)
    !run |=> !on && !s_r.busy)
    else $error("led active while suspended");
endmodule // tpslc_led
`default_nettype wire

// File: hdl/tpslc_top.sv
// Purpose: Power states, reset pin, touch gating and LED control with AXI4-Lite registers
// Assumes: touch_raw, lid_raw, grp_up, grp_down and bus_activity come from aclk logic
// Notes: ALERT is active low and open drain; LEDs sink current when lit
`timescale 1ns/1ps
`default_nettype none
module tpslc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin,
  input wire logic alert_in,
  input wire logic bus_activity,
  input wire logic [13:0] touch_raw,
  input wire logic [13:0] lid_raw,
  input wire logic grp_up,
  input wire logic grp_down,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [10:0] led_out,
  output logic [10:0] led_oe,
  output logic alert_out,
  output logic alert_oe,
  output logic [1:0] power_state,
  output logic [13:0] sense_enable
);
  typedef struct packed {
    logic sl, ia, ds, pwr_ctl, link_en, slider_pos;
    tpslc_pkg::tpslc_pstate_t pstate;
    logic rst_flag, lid_flag, done_flag, lid_ev, lid_irq_en;
    logic [13:0] sleep_mask, touch, press, lid_sel, sense;
    logic [10:0] drive, done_en, inv, led_o, led_oe;
    logic [23:0] mode;
    logic [7:0] pp_sel, bright, slider;
    logic [3:0] pulses, max_btn, max_grp, lid_min, div;
    logic tgl, a1, a2, alert_oe;
    logic [1:0] guard;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } tpslc_main_t;
  tpslc_main_t s_r, s_nxt;

  logic hold, released, rst_n_int, tick, tick_pwr;
  logic [10:0] run, stim, led_on, led_done;
  logic [1:0] led_mode [11];

  function automatic logic [3:0] popc(input logic [13:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 14; i++) c = c + {3'h0, v[i]};
    return c;
  endfunction

  // Read map: bit 32 marks a mapped offset
  function automatic logic [32:0] rmap(input logic [7:0] a, input tpslc_main_t q);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    unique case (a)
      tpslc_pkg::OFS_CTRL: r[5:0] = {q.slider_pos, q.link_en, q.pwr_ctl, q.ds, q.ia, q.sl};
      tpslc_pkg::OFS_STAT: r[5:0] = {q.lid_ev, q.done_flag, q.lid_flag, q.rst_flag, q.pstate};
      tpslc_pkg::OFS_SMASK: r[13:0] = q.sleep_mask;
      tpslc_pkg::OFS_TOUCH: r[13:0] = q.touch;
      tpslc_pkg::OFS_DRIVE: r[10:0] = q.drive;
      tpslc_pkg::OFS_MODE: r[23:0] = q.mode;
      tpslc_pkg::OFS_PPSEL: r[7:0] = q.pp_sel;
      tpslc_pkg::OFS_LIMIT: r[12:0] = {q.lid_irq_en, q.lid_min, q.max_grp, q.max_btn};
      tpslc_pkg::OFS_LIDSEL: r[13:0] = q.lid_sel;
      tpslc_pkg::OFS_SLIDER: r[7:0] = q.slider;
      tpslc_pkg::OFS_LEDCFG: r[11:0] = {q.pulses, q.bright};
      tpslc_pkg::OFS_LEDALT: r[26:0] = {q.inv, 5'h00, q.done_en};
      default: r = '0;
    endcase
    return r;
  endfunction

  tpslc_rst_filter u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(reset_pin),
    .hold(hold),
    .released(released)
  );
  assign rst_n_int = aresetn && !hold;
  assign tick = s_r.div == 4'h0;
  assign tick_pwr = tick && s_r.tgl;

  ////////////////////////////////////////////////////////////////////////////
  // LED channels
  generate
    for (genvar i = 0; i < 11; i++) begin : g_led
      if (i == 10) begin : g_pwr
        logic lowpow;
        assign lowpow = s_r.pstate == tpslc_pkg::PS_SLEEP || s_r.pstate == tpslc_pkg::PS_DEEP;
        assign run[i] = s_r.pstate != tpslc_pkg::PS_INACT;
        assign stim[i] = (lowpow ? s_r.pwr_ctl : s_r.drive[i]) ^ s_r.inv[i];
        assign led_mode[i] = lowpow ? s_r.mode[23:22] : s_r.mode[21:20];
      end else begin : g_std
        assign run[i] = s_r.pstate == tpslc_pkg::PS_ACTIVE ||
                        s_r.pstate == tpslc_pkg::PS_SLEEP;
        if (i < 7) begin : g_btn
          assign stim[i] = (s_r.link_en ? s_r.press[i] : s_r.drive[i]) ^ s_r.inv[i];
        end else if (i == 8 || i == 9) begin : g_grp
          assign stim[i] = (s_r.link_en ? (i == 8 ? grp_up : grp_down) : s_r.drive[i])
                           ^ s_r.inv[i];
        end else begin : g_host
          assign stim[i] = s_r.drive[i] ^ s_r.inv[i];
        end
        assign led_mode[i] = s_r.mode[2*i+1 -: 2];
      end
      tpslc_led u_led (
        .aclk(aclk),
        .rst_n(rst_n_int),
        .run(run[i]),
        .tick(i == 10 ? tick_pwr : tick),
        .stim(stim[i]),
        .mode(led_mode[i]),
        .bright(s_r.bright),
        .pulses(s_r.pulses),
        .on(led_on[i]),
        .done(led_done[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic wfire, rfire, lidhit, irq;
  logic [31:0] wv, m;
  logic [32:0] rv;
  logic [13:0] act, p, sense_n;
  logic [10:0] linked;
  logic [3:0] cnt;
  tpslc_pkg::tpslc_pstate_t ps_n;

  always_comb begin
    s_nxt = s_r;
    s_nxt.awready = 1'b0;
    s_nxt.wready = 1'b0;
    s_nxt.arready = 1'b0;
    s_nxt.a1 = alert_in;
    s_nxt.a2 = s_r.a1;
    s_nxt.div = tick ? 4'(tpslc_pkg::PWM_DIV - 1) : s_r.div - 4'h1;
    s_nxt.tgl = s_r.tgl ^ tick;
    if (s_r.bvalid && bready) s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && rready) s_nxt.rvalid = 1'b0;
    if (awvalid && wvalid && !s_r.awready && !s_r.bvalid) begin
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end
    if (arvalid && !s_r.arready && !s_r.rvalid) s_nxt.arready = 1'b1;
    wfire = s_r.awready && awvalid && wvalid;
    rfire = s_r.arready && arvalid;
    for (int b = 0; b < 4; b++) m[8*b +: 8] = {8{wstrb[b]}};
    rv = rmap(awaddr, s_r);
    wv = (rv[31:0] & ~m) | (wdata & m);
    if (wfire) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = rv[32] ? tpslc_pkg::RESP_OKAY : tpslc_pkg::RESP_SLVERR;
      unique case (awaddr)
        tpslc_pkg::OFS_CTRL: begin
          s_nxt.sl = wv[tpslc_pkg::CTRL_SLEEP];
          s_nxt.ia = wv[tpslc_pkg::CTRL_INACT];
          s_nxt.ds = wv[tpslc_pkg::CTRL_DEEP];
          s_nxt.pwr_ctl = wv[tpslc_pkg::CTRL_PWR];
          s_nxt.link_en = wv[tpslc_pkg::CTRL_LINK];
          s_nxt.slider_pos = wv[tpslc_pkg::CTRL_SLPOS];
        end
        tpslc_pkg::OFS_STAT: begin
          s_nxt.rst_flag = s_r.rst_flag && !(wdata[tpslc_pkg::STAT_RST] && wstrb[0]);
          s_nxt.lid_flag = s_r.lid_flag && !(wdata[tpslc_pkg::STAT_LID] && wstrb[0]);
          s_nxt.done_flag = s_r.done_flag && !(wdata[tpslc_pkg::STAT_DONE] && wstrb[0]);
        end
        tpslc_pkg::OFS_SMASK: s_nxt.sleep_mask = wv[13:0];
        tpslc_pkg::OFS_TOUCH: s_nxt.touch = s_r.touch & ~(wdata[13:0] & m[13:0]);
        tpslc_pkg::OFS_DRIVE: s_nxt.drive = wv[10:0];
        tpslc_pkg::OFS_MODE: s_nxt.mode = wv[23:0];
        tpslc_pkg::OFS_PPSEL: s_nxt.pp_sel = wv[7:0];
        tpslc_pkg::OFS_LIMIT: {s_nxt.lid_irq_en, s_nxt.lid_min, s_nxt.max_grp,
                               s_nxt.max_btn} = wv[12:0];
        tpslc_pkg::OFS_LIDSEL: s_nxt.lid_sel = wv[13:0];
        tpslc_pkg::OFS_SLIDER: s_nxt.slider = wv[7:0];
        tpslc_pkg::OFS_LEDCFG: {s_nxt.pulses, s_nxt.bright} = wv[11:0];
        tpslc_pkg::OFS_LEDALT: {s_nxt.inv, s_nxt.done_en} = {wv[26:16], wv[10:0]};
        default: ;
      endcase
    end
    if (rfire) begin
      rv = rmap(araddr, s_r);
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rv[31:0];
      s_nxt.rresp = rv[32] ? tpslc_pkg::RESP_OKAY : tpslc_pkg::RESP_SLVERR;
    end
    // Our own alert drive still lingers in the synchroniser after release
    if (s_r.guard != 2'h0) s_nxt.guard = s_r.guard - 2'h1;
    if (s_r.pstate == tpslc_pkg::PS_DEEP &&
        ((!s_r.a2 && s_r.guard == 2'h0) || bus_activity)) s_nxt.ds = 1'b0;
    ps_n = s_nxt.ds ? tpslc_pkg::PS_DEEP :
           s_nxt.ia ? tpslc_pkg::PS_INACT :
           s_nxt.sl ? tpslc_pkg::PS_SLEEP : tpslc_pkg::PS_ACTIVE;
    unique case (ps_n)
      tpslc_pkg::PS_ACTIVE: sense_n = '1;
      tpslc_pkg::PS_SLEEP: sense_n = s_nxt.sleep_mask;
      default: sense_n = '0;
    endcase
    // Touch qualification
    act = touch_raw & s_r.sense;
    lidhit = (s_r.lid_min != 4'h0 && popc(lid_raw) >= s_r.lid_min) ||
             (s_r.lid_sel != '0 && (lid_raw & s_r.lid_sel) == s_r.lid_sel);
    s_nxt.lid_ev = lidhit;
    if (lidhit) s_nxt.lid_flag = 1'b1;
    p = s_r.press & act;
    cnt = popc({7'h00, p[6:0]});
    for (int i = 0; i < 7; i++) begin
      if (act[i] && !p[i] && cnt < s_r.max_btn && !s_r.lid_ev) begin
        p[i] = 1'b1;
        cnt = cnt + 4'h1;
        s_nxt.touch[i] = 1'b1;
      end
    end
    if (popc({act[13:7], 7'h00}) > s_r.max_grp) begin
      p[13:7] = '0;
    end else if (!s_r.lid_ev) begin
      s_nxt.touch[13:7] = s_nxt.touch[13:7] | (act[13:7] & ~p[13:7]);
      p[13:7] = act[13:7];
    end
    s_nxt.press = p;
    if (ps_n != s_r.pstate) begin
      s_nxt.touch = s_nxt.touch & sense_n;
      s_nxt.press = s_nxt.press & sense_n;
      if (ps_n == tpslc_pkg::PS_DEEP) s_nxt.guard = tpslc_pkg::ALERT_GUARD;
      if (ps_n == tpslc_pkg::PS_DEEP && s_nxt.slider_pos) s_nxt.slider = 8'h00;
    end
    s_nxt.pstate = ps_n;
    s_nxt.sense = sense_n;
    linked = s_r.link_en ? 11'h37F : 11'h000;
    if (|(led_done & s_r.done_en & ~linked)) s_nxt.done_flag = 1'b1;
    if (released) s_nxt.rst_flag = 1'b1;
    irq = s_nxt.rst_flag || s_nxt.done_flag || (s_nxt.lid_flag && s_nxt.lid_irq_en) ||
          |s_nxt.touch;
    s_nxt.alert_oe = irq && ps_n != tpslc_pkg::PS_DEEP;
    for (int i = 0; i < 11; i++) begin
      if (i < 8 && s_r.pp_sel[i]) begin
        s_nxt.led_oe[i] = 1'b1;
        s_nxt.led_o[i] = !led_on[i];
      end else begin
        s_nxt.led_oe[i] = led_on[i];
        s_nxt.led_o[i] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      s_r <= '0;
      s_r.a1 <= 1'b1;
      s_r.a2 <= 1'b1;
      s_r.bright <= tpslc_pkg::RST_BRIGHT;
      s_r.pulses <= tpslc_pkg::RST_PULSES;
      s_r.max_btn <= tpslc_pkg::RST_MAX_BTN;
      s_r.max_grp <= tpslc_pkg::RST_MAX_GRP;
      s_r.sense <= hold ? '0 : '1;
      s_r.pstate <= hold ? tpslc_pkg::PS_DEEP : tpslc_pkg::PS_ACTIVE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign led_out = s_r.led_o;
  assign led_oe = s_r.led_oe;
  assign alert_out = 1'b0;
  assign alert_oe = s_r.alert_oe;
  assign power_state = s_r.pstate;
  assign sense_enable = s_r.sense;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_DEEP_PRIO: assert property (s_r.ds |-> s_r.pstate == tpslc_pkg::PS_DEEP)
    else $error("deep sleep bit not dominant");
  AST_INACT_PRIO: assert property (s_r.ia && !s_r.ds |->
    s_r.pstate == tpslc_pkg::PS_INACT && sense_enable == '0)
    else $error("inactive request not honoured");
  AST_SLEEP_MASK: assert property (s_r.pstate == tpslc_pkg::PS_SLEEP |->
    sense_enable == s_r.sleep_mask)
    else $error("sleep sensing differs from mask");
  AST_TOUCH_CLR: assert property ($changed(s_r.pstate) |->
    (s_r.touch & ~sense_enable) == '0)
    else $error("stale touch kept after state change");
  AST_ALERT_REL: assert property (s_r.pstate == tpslc_pkg::PS_DEEP |-> !alert_oe)
    else $error("alert driven in deep sleep");
  AST_WAKE: assert property (s_r.pstate == tpslc_pkg::PS_DEEP && bus_activity && !hold
    |=> !s_r.ds && s_r.pstate != tpslc_pkg::PS_DEEP)
    else $error("no wake on bus activity");
  AST_RST_FLAG: assert property (released |=> s_r.rst_flag ##1 alert_oe)
    else $error("reset release not flagged");
  AST_HOLD: assert property (hold |=> power_state == tpslc_pkg::PS_DEEP &&
    sense_enable == '0)
    else $error("filtered reset not holding deep sleep");
  AST_LID_BLOCK: assert property (s_r.lid_ev |=> (s_r.press & ~$past(s_r.press)) == '0)
    else $error("touch accepted during lid event");
  AST_BTN_LIMIT: assert property ($past(s_r.max_btn) == s_r.max_btn &&
    popc({7'h00, $past(s_r.press[6:0])}) <= s_r.max_btn |->
    popc({7'h00, s_r.press[6:0]}) <= s_r.max_btn)
    else $error("too many buttons flagged");
  AST_DEEP_LED: assert property ((s_r.pstate == tpslc_pkg::PS_DEEP)[*3] |->
    led_on[9:0] == '0)
    else $error("led active in deep sleep");

  COV_DEEP: cover property (s_r.pstate == tpslc_pkg::PS_ACTIVE ##1
    s_r.pstate == tpslc_pkg::PS_DEEP);
  COV_WAKE_ALERT: cover property (s_r.pstate == tpslc_pkg::PS_DEEP && !s_r.a2 ##1
    s_r.pstate != tpslc_pkg::PS_DEEP);
  COV_LID: cover property ($rose(s_r.lid_ev));
  COV_RST: cover property (released);
endmodule // tpslc_top
`default_nettype wire

// File: test/tpslc_host_model.sv
// Purpose: Host side of the shared open-drain alert line
// Assumes: A wake request is raised for whole clock cycles
// Notes: The line rests high through its pull-up when nobody pulls it
`timescale 1ns/1ps
`default_nettype none
module tpslc_host_model (
  input wire logic aclk,
  input wire logic alert_oe,
  input wire logic wake_req,
  output logic alert_wire
);
  logic pull_low_r = 1'b0;
  // Host pulls the line low one cycle after the request, for as many cycles as it lasts
  always_ff @(posedge aclk) begin
    pull_low_r <= wake_req;
  end
  assign alert_wire = (alert_oe || pull_low_r) ? 1'b0 : 1'b1;
endmodule // tpslc_host_model
`default_nettype wire

// File: test/tb.sv
// Purpose: Self-checking bench for power states, reset pin and touch flags
// Assumes: Register access over AXI4-Lite on aclk
// Notes: Reset filter runs at its full length of 500 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic reset_pin = 1'b0;
  logic bus_activity = 1'b0;
  logic wake_req = 1'b0;
  logic [13:0] touch_raw = 14'h0000;
  logic [13:0] lid_raw = 14'h0000;
  logic grp_up = 1'b0;
  logic grp_down = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, alert_in, alert_out, alert_oe;
  logic [1:0] bresp, rresp, power_state, resp;
  logic [31:0] rdata, rd_v;
  logic [10:0] led_out, led_oe;
  logic [13:0] sense_enable;
  int num_errors = 0;
  int checks = 0;
  int v;
  tpslc_top u_dut (.aclk, .aresetn, .reset_pin, .alert_in, .bus_activity, .touch_raw,
    .lid_raw, .grp_up, .grp_down, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .led_out, .led_oe, .alert_out, .alert_oe, .power_state,
    .sense_enable);
  tpslc_host_model u_host (.aclk, .alert_oe, .wake_req, .alert_wire(alert_in));
  initial forever #10 aclk = ~aclk;
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 100) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_v = rdata;
    resp = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(4);
    aresetn <= 1'b1;
    rd(tpslc_pkg::OFS_LEDCFG);
    chk(rd_v, 32'h0000_03FF);
    rd(tpslc_pkg::OFS_LIMIT);
    chk(rd_v, 32'h0000_0033);
    chk(sense_enable, 32'h0000_3FFF);
    wr(8'hF0, 32'h0000_00FF);
    chk(resp, tpslc_pkg::RESP_SLVERR);
    rd(8'hF0);
    chk(rd_v, 32'h0000_0000);
    chk(resp, tpslc_pkg::RESP_SLVERR);
    $display("test defaults done");
    for (v = 0; v < 8; v++) begin
      wr(tpslc_pkg::OFS_CTRL, v);
      cyc(1);
      chk(power_state, v[2] ? 2 : v[1] ? 3 : v[0]);
      chk(sense_enable, (v[2] | v[1] | v[0]) ? 0 : 14'h3FFF);
      if (v[2]) begin
        chk(alert_oe, 32'h0000_0000);
        bus_activity <= 1'b1;
        @(posedge aclk) bus_activity <= 1'b0;
        cyc(3);
        chk(power_state, v[1] ? 3 : v[0]);
        rd(tpslc_pkg::OFS_CTRL);
        chk(rd_v, v & 3);
      end
    end
    $display("test power states done");
    wr(tpslc_pkg::OFS_SLIDER, 32'h0000_0055);
    wr(tpslc_pkg::OFS_CTRL, 32'h0000_0024);
    cyc(6);
    wake_req <= 1'b1;
    cyc(4);
    wake_req <= 1'b0;
    cyc(4);
    chk(power_state, 32'h0000_0000);
    rd(tpslc_pkg::OFS_SLIDER);
    chk(rd_v, 32'h0000_0000);
    rd(tpslc_pkg::OFS_CTRL);
    chk(rd_v, 32'h0000_0020);
    $display("test alert wake done");
    for (v = 0; v < 4; v++) begin
      touch_raw[v] <= 1'b1;
      cyc(2);
    end
    rd(tpslc_pkg::OFS_TOUCH);
    chk(rd_v, 32'h0000_0007);
    chk(alert_oe, 32'h0000_0001);
    touch_raw <= 14'h0000;
    wr(tpslc_pkg::OFS_CTRL, 32'h0000_0001);
    rd(tpslc_pkg::OFS_TOUCH);
    chk(rd_v, 32'h0000_0000);
    wr(tpslc_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test touch done");
    wr(tpslc_pkg::OFS_LEDCFG, 32'h0000_0000);
    reset_pin <= 1'b1;
    cyc(100);
    reset_pin <= 1'b0;
    cyc(10);
    chk(power_state, 32'h0000_0000);
    reset_pin <= 1'b1;
    cyc(520);
    chk(power_state, 32'h0000_0002);
    chk(sense_enable, 32'h0000_0000);
    reset_pin <= 1'b0;
    cyc(520);
    chk(alert_oe, 32'h0000_0001);
    rd(tpslc_pkg::OFS_STAT);
    chk(rd_v, 32'h0000_0004);
    rd(tpslc_pkg::OFS_LEDCFG);
    chk(rd_v, 32'h0000_03FF);
    wr(tpslc_pkg::OFS_STAT, 32'h0000_0004);
    rd(tpslc_pkg::OFS_STAT);
    chk(rd_v, 32'h0000_0000);
    $display("test reset pin done");
    wr(tpslc_pkg::OFS_PPSEL, 32'h0000_0002);
    wr(tpslc_pkg::OFS_DRIVE, 32'h0000_0001);
    cyc(2);
    chk(led_oe, 32'h0000_0003);
    chk(led_out, 32'h0000_0002);
    wr(tpslc_pkg::OFS_CTRL, 32'h0000_000C);
    cyc(2);
    chk(led_oe, 32'h0000_0402);
    chk(led_out, 32'h0000_0002);
    chk(alert_out, 32'h0000_0000);
    wr(tpslc_pkg::OFS_CTRL, 32'h0000_0002);
    cyc(2);
    chk(led_oe, 32'h0000_0002);
    wr(tpslc_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test leds done");
    wr(tpslc_pkg::OFS_LIMIT, 32'h0000_0233);
    lid_raw <= 14'h0003;
    cyc(2);
    touch_raw <= 14'h0001;
    cyc(2);
    rd(tpslc_pkg::OFS_STAT);
    chk(rd_v, 32'h0000_0028);
    rd(tpslc_pkg::OFS_TOUCH);
    chk(rd_v, 32'h0000_0000);
    lid_raw <= 14'h0000;
    cyc(2);
    rd(tpslc_pkg::OFS_TOUCH);
    chk(rd_v, 32'h0000_0001);
    $display("test lid done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
